// ### design/crf_regs.sv
// Purpose: programmer-visible register set with condition flags
// Assumes: driven only by the instruction datapath on the same clock
// Notes: reset sets the two interrupt mask flags and clears the three gates and ea_ok
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.svh"
module crf_regs
   import crf_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire crf_sel_t i_wr_sel,
   input wire logic [15:0] i_wr_data,
   input wire crf_op_t i_op,
   input wire logic [15:0] i_op_b,
   input wire logic i_sp_push,
   input wire logic i_sp_pop,
   input wire logic [3:0] i_sp_step,
   input wire crf_base_t i_ea_base,
   input wire crf_ofs_t i_ea_ofs,
   input wire logic [15:0] i_ea_const,
   input wire logic i_ea_autoidx,
   input wire logic i_halt_req,
   input wire logic i_hp_irq_req,
   input wire logic i_irq_req,
   output logic [7:0] o_acc_hi,
   output logic [7:0] o_acc_lo,
   output logic [15:0] o_dbl_acc,
   output logic [15:0] o_idx1,
   output logic [15:0] o_idx2,
   output logic [15:0] o_stack,
   output logic [15:0] o_pc,
   output logic [7:0] o_flags,
   output logic [15:0] o_ea,
   output logic o_ea_ok,
   output logic o_halt_ok,
   output logic o_hp_irq_ok,
   output logic o_irq_ok
);
   // -------------------------------------------------------------
   // state and helpers
   // -------------------------------------------------------------
   crf_state_t s_q;
   crf_state_t s_d;
   crf_alu_if alu_bus ();
   logic [15:0] base_val;
   logic [15:0] ofs_val;
   // every check samples on the core clock and rests in reset
   default clocking cb_chk @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   // 16-bit word written as one unit keeps both bytes together
   function automatic logic [15:0] crf_word(input logic [7:0] hi, input logic [7:0] lo);
      crf_word = {hi, lo};
   endfunction : crf_word

   // 16-bit ops write both accumulators, 8-bit ops only the high one
   function automatic logic crf_is_wide(input crf_op_t op);
      crf_is_wide = (op == CRF_OP_ADD16) || (op == CRF_OP_SUB16);
   endfunction : crf_is_wide

   crf_alu u_alu (
      .bus(alu_bus)
   );

   // adder operands; accumulator ops target the high accumulator
   always_comb
   begin
      alu_bus.op = i_op;
      alu_bus.a = crf_is_wide(i_op)
                  ? crf_word(s_q.acc_hi, s_q.acc_lo) : {8'h00, s_q.acc_hi};
      alu_bus.b = i_op_b;
      alu_bus.cin = s_q.flags[`CRF_FLG_CARRY];
      alu_bus.half_in = s_q.flags[`CRF_FLG_HALF];
   end

   // -------------------------------------------------------------
   // effective address
   // -------------------------------------------------------------
   // pc may not be auto-indexed, so that base is refused
   always_comb
   begin
      case (i_ea_base)
         CRF_BASE_IDX1: base_val = s_q.idx1;
         CRF_BASE_IDX2: base_val = s_q.idx2;
         CRF_BASE_STACK: base_val = s_q.stack;
         CRF_BASE_PC: base_val = s_q.pc;
         default: base_val = 16'h0000;
      endcase
      case (i_ea_ofs)
         CRF_OFS_CONST: ofs_val = i_ea_const;
         CRF_OFS_ACC_HI: ofs_val = {8'h00, s_q.acc_hi};
         CRF_OFS_ACC_LO: ofs_val = {8'h00, s_q.acc_lo};
         CRF_OFS_DBL: ofs_val = crf_word(s_q.acc_hi, s_q.acc_lo);
         default: ofs_val = 16'h0000;
      endcase
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   // datapath write wins over arithmetic on the same register
   always_comb
   begin
      s_d = s_q;
      s_d.ea = base_val + ofs_val;
      s_d.ea_ok = !(i_ea_autoidx && i_ea_base == CRF_BASE_PC);
      if (i_op != CRF_OP_NONE)
      begin
         if (crf_is_wide(i_op))
         begin
            s_d.acc_hi = alu_bus.res[15:8];
            s_d.acc_lo = alu_bus.res[7:0];
         end
         else
         begin
            s_d.acc_hi = alu_bus.res[7:0];
         end
         s_d.flags = (s_q.flags & ~alu_bus.flag_mask)
                     | (alu_bus.flags & alu_bus.flag_mask);
      end
      // stack moves for context save and restore
      if (i_sp_push)
      begin
         s_d.stack = s_q.stack - {12'h000, i_sp_step};
      end
      else if (i_sp_pop)
      begin
         s_d.stack = s_q.stack + {12'h000, i_sp_step};
      end
      case (i_wr_sel)
         CRF_SEL_ACC_HI: s_d.acc_hi = i_wr_data[7:0];
         CRF_SEL_ACC_LO: s_d.acc_lo = i_wr_data[7:0];
         CRF_SEL_DBL:
         begin
            s_d.acc_hi = i_wr_data[15:8];
            s_d.acc_lo = i_wr_data[7:0];
         end
         CRF_SEL_IDX1: s_d.idx1 = i_wr_data;
         CRF_SEL_IDX2: s_d.idx2 = i_wr_data;
         CRF_SEL_STACK: s_d.stack = i_wr_data;
         CRF_SEL_PC: s_d.pc = i_wr_data;
         CRF_SEL_FLAGS: s_d.flags = i_wr_data[7:0];
         default: s_d.pc = s_q.pc;
      endcase
      // gates derived from the flags held this cycle, before any write or op lands
      s_d.halt_ok = i_halt_req && !s_q.flags[`CRF_FLG_HALT_INH];
      s_d.hp_irq_ok = i_hp_irq_req && !s_q.flags[`CRF_FLG_HP_MASK];
      s_d.irq_ok = i_irq_req && !s_q.flags[`CRF_FLG_IRQ_MASK];
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   // reset sets masks, clears gates and freezes data so no write lands
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s_q.flags[`CRF_FLG_HP_MASK] <= 1'b1;
         s_q.flags[`CRF_FLG_IRQ_MASK] <= 1'b1;
         s_q.halt_ok <= 1'b0;
         s_q.hp_irq_ok <= 1'b0;
         s_q.irq_ok <= 1'b0;
         s_q.ea_ok <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs are flops of the state
   assign o_acc_hi = s_q.acc_hi;
   assign o_acc_lo = s_q.acc_lo;
   assign o_dbl_acc = {s_q.acc_hi, s_q.acc_lo};
   assign o_idx1 = s_q.idx1;
   assign o_idx2 = s_q.idx2;
   assign o_stack = s_q.stack;
   assign o_pc = s_q.pc;
   assign o_flags = s_q.flags;
   assign o_ea = s_q.ea;
   assign o_ea_ok = s_q.ea_ok;
   assign o_halt_ok = s_q.halt_ok;
   assign o_hp_irq_ok = s_q.hp_irq_ok;
   assign o_irq_ok = s_q.irq_ok;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   a_dbl_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_wr_sel == CRF_SEL_DBL |=> o_dbl_acc == $past(i_wr_data))
      else $error("double accumulator write lost");
   a_byte_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr_sel == CRF_SEL_ACC_LO) |=> o_dbl_acc[7:0] == $past(i_wr_data[7:0]))
      else $error("low accumulator not in double");
   a_halt_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_flags[`CRF_FLG_HALT_INH] && i_halt_req |=> !o_halt_ok)
      else $error("halt passed while inhibited");
   a_hp_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_flags[`CRF_FLG_HP_MASK] |=> !o_hp_irq_ok)
      else $error("pin request passed while masked");
   a_irq_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_irq_req && !o_flags[`CRF_FLG_IRQ_MASK] |=> o_irq_ok)
      else $error("unmasked request dropped");
   a_zero_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_op == CRF_OP_ADD8 && i_wr_sel == CRF_SEL_NONE |=> o_flags[`CRF_FLG_ZERO] == (o_acc_hi == 8'h00))
      else $error("zero flag wrong");
   a_neg_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_op == CRF_OP_ADD16 && i_wr_sel == CRF_SEL_NONE |=> o_flags[`CRF_FLG_NEG] == o_dbl_acc[15])
      else $error("negative flag wrong");
   a_pc_autoidx: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_ea_autoidx && i_ea_base == CRF_BASE_PC |=> !o_ea_ok)
      else $error("pc accepted as auto-index base");
   a_ea_sum: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_ea_base == CRF_BASE_IDX1 && i_ea_ofs == CRF_OFS_CONST |=> o_ea == $past(o_idx1) + $past(i_ea_const))
      else $error("effective address wrong");
   c_daa: cover property (@(posedge i_sys_clk) i_op == CRF_OP_DAA);
   c_carry: cover property (@(posedge i_sys_clk) i_op == CRF_OP_ADD8 ##1 o_flags[`CRF_FLG_CARRY]);
   c_push: cover property (@(posedge i_sys_clk) i_sp_push);
   c_hp_pass: cover property (@(posedge i_sys_clk) o_hp_irq_ok);
   c_pc_refused: cover property (@(posedge i_sys_clk) i_ea_autoidx ##1 !o_ea_ok);

   // -------------------------------------------------------------
   // checks: register writes and moves
   // -------------------------------------------------------------
   // a write or a move shows whole on the very next edge
   a_hi_write: assert property (
      i_wr_sel == CRF_SEL_ACC_HI
      |=> o_acc_hi == $past(i_wr_data[7:0]))
      else $error("high accumulator write lost");
   a_lo_keep: assert property (
      i_op == CRF_OP_ADD8 && i_wr_sel == CRF_SEL_NONE
      |=> o_acc_lo == $past(o_acc_lo))
      else $error("byte op touched low accumulator");
   a_idx1_write: assert property (
      i_wr_sel == CRF_SEL_IDX1
      |=> o_idx1 == $past(i_wr_data))
      else $error("first index write lost");
   a_idx2_write: assert property (
      i_wr_sel == CRF_SEL_IDX2
      |=> o_idx2 == $past(i_wr_data))
      else $error("second index write lost");
   a_stack_write: assert property (
      i_wr_sel == CRF_SEL_STACK
      |=> o_stack == $past(i_wr_data))
      else $error("stack write lost");
   a_stack_push: assert property (
      i_sp_push && i_wr_sel != CRF_SEL_STACK
      |=> o_stack == $past(o_stack) - {12'h000, $past(i_sp_step)})
      else $error("stack push step wrong");
   a_stack_pop: assert property (
      i_sp_pop && !i_sp_push && i_wr_sel != CRF_SEL_STACK
      |=> o_stack == $past(o_stack) + {12'h000, $past(i_sp_step)})
      else $error("stack pop step wrong");
   a_pc_write: assert property (
      i_wr_sel == CRF_SEL_PC
      |=> o_pc == $past(i_wr_data))
      else $error("pc write lost");
   a_ea_ok_set: assert property (
      !(i_ea_autoidx && i_ea_base == CRF_BASE_PC)
      |=> o_ea_ok)
      else $error("legal address refused");
   a_ea_dbl_ofs: assert property (
      i_ea_base == CRF_BASE_STACK && i_ea_ofs == CRF_OFS_DBL
      |=> o_ea == $past(o_stack) + $past(o_dbl_acc))
      else $error("stack plus double offset wrong");
   a_dbl_add16: assert property (
      i_op == CRF_OP_ADD16 && i_wr_sel == CRF_SEL_NONE
      |=> o_dbl_acc == $past(o_dbl_acc) + $past(i_op_b))
      else $error("wide sum not split over both bytes");
   a_flags_write: assert property (
      i_wr_sel == CRF_SEL_FLAGS
      |=> o_flags == $past(i_wr_data[7:0]))
      else $error("flag write lost");

   // -------------------------------------------------------------
   // checks: flags and gates
   // -------------------------------------------------------------
   // flags worked out again from the operands and the registered result, not from the adder
   a_half_add: assert property (
      i_op == CRF_OP_ADD8 && i_wr_sel == CRF_SEL_NONE
      |=> o_flags[`CRF_FLG_HALF] ==
         (({1'b0, $past(o_acc_hi[3:0])} + {1'b0, $past(i_op_b[3:0])}) > 5'h0f))
      else $error("half carry wrong");
   a_carry_add: assert property (
      i_op == CRF_OP_ADD8 && i_wr_sel == CRF_SEL_NONE
      |=> o_flags[`CRF_FLG_CARRY] ==
         (({1'b0, $past(o_acc_hi)} + {1'b0, $past(i_op_b[7:0])}) > 9'h0ff))
      else $error("carry wrong");
   a_borrow_sub: assert property (
      i_op == CRF_OP_SUB8 && i_wr_sel == CRF_SEL_NONE
      |=> o_flags[`CRF_FLG_CARRY] == ($past(i_op_b[7:0]) > $past(o_acc_hi)))
      else $error("borrow wrong");
   a_ovf_add: assert property (
      i_op == CRF_OP_ADD8 && i_wr_sel == CRF_SEL_NONE
      |=> o_flags[`CRF_FLG_OVF] == ($past(o_acc_hi[7]) == $past(i_op_b[7])
         && o_acc_hi[7] != $past(o_acc_hi[7])))
      else $error("overflow wrong");
   a_neg_add8: assert property (
      i_op == CRF_OP_ADD8 && i_wr_sel == CRF_SEL_NONE
      |=> o_flags[`CRF_FLG_NEG] == o_acc_hi[7])
      else $error("byte negative flag wrong");
   a_zero_add16: assert property (
      i_op == CRF_OP_ADD16 && i_wr_sel == CRF_SEL_NONE
      |=> o_flags[`CRF_FLG_ZERO] == (o_dbl_acc == 16'h0000))
      else $error("wide zero flag wrong");
   a_daa_carry: assert property (
      i_op == CRF_OP_DAA && i_wr_sel == CRF_SEL_NONE && o_flags[`CRF_FLG_CARRY]
      |=> o_flags[`CRF_FLG_CARRY])
      else $error("decimal adjust dropped carry");
   // the gates must open as well as shut
   a_halt_open: assert property (
      i_halt_req && !o_flags[`CRF_FLG_HALT_INH]
      |=> o_halt_ok)
      else $error("allowed halt dropped");
   a_hp_open: assert property (
      i_hp_irq_req && !o_flags[`CRF_FLG_HP_MASK]
      |=> o_hp_irq_ok)
      else $error("unmasked pin request dropped");
   a_irq_block: assert property (
      o_flags[`CRF_FLG_IRQ_MASK]
      |=> !o_irq_ok)
      else $error("request passed while masked");
   // first edge after release still sees the reset values
   a_reset_masks: assert property (
      $rose(i_rst_n)
      |-> o_flags[`CRF_FLG_HP_MASK] && o_flags[`CRF_FLG_IRQ_MASK]
         && !o_halt_ok && !o_hp_irq_ok && !o_irq_ok)
      else $error("reset state wrong");
endmodule : crf_regs
`default_nettype wire

// ### shared/crf_consts.svh
// Purpose: constants for the processor register set and flag logic
// Assumes: included by bare name from design files
// Notes: flag positions inside the condition flag byte
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH
`define CRF_FLG_HALT_INH 7
`define CRF_FLG_HP_MASK 6
`define CRF_FLG_HALF 5
`define CRF_FLG_IRQ_MASK 4
`define CRF_FLG_NEG 3
`define CRF_FLG_ZERO 2
`define CRF_FLG_OVF 1
`define CRF_FLG_CARRY 0
`define CRF_QUEUE_MIN 3
`define CRF_EXT_W 20
`endif

// ### shared/crf_pkg.sv
// Purpose: types for the processor register set
// Assumes: nothing
// Notes: register select codes used by the write port
package crf_pkg;
   typedef enum logic [3:0] {
      CRF_SEL_NONE = 4'h0,
      CRF_SEL_ACC_HI = 4'h1,
      CRF_SEL_ACC_LO = 4'h2,
      CRF_SEL_DBL = 4'h3,
      CRF_SEL_IDX1 = 4'h4,
      CRF_SEL_IDX2 = 4'h5,
      CRF_SEL_STACK = 4'h6,
      CRF_SEL_PC = 4'h7,
      CRF_SEL_FLAGS = 4'h8
   } crf_sel_t;
   typedef enum logic [2:0] {
      CRF_OP_NONE = 3'h0,
      CRF_OP_ADD8 = 3'h1,
      CRF_OP_ADC8 = 3'h2,
      CRF_OP_SUB8 = 3'h3,
      CRF_OP_DAA = 3'h4,
      CRF_OP_ADD16 = 3'h5,
      CRF_OP_SUB16 = 3'h6
   } crf_op_t;
   typedef enum logic [1:0] {
      CRF_BASE_IDX1 = 2'h0,
      CRF_BASE_IDX2 = 2'h1,
      CRF_BASE_STACK = 2'h2,
      CRF_BASE_PC = 2'h3
   } crf_base_t;
   typedef enum logic [1:0] {
      CRF_OFS_CONST = 2'h0,
      CRF_OFS_ACC_HI = 2'h1,
      CRF_OFS_ACC_LO = 2'h2,
      CRF_OFS_DBL = 2'h3
   } crf_ofs_t;
   typedef struct packed {
      logic [7:0] acc_hi;
      logic [7:0] acc_lo;
      logic [15:0] idx1;
      logic [15:0] idx2;
      logic [15:0] stack;
      logic [15:0] pc;
      logic [7:0] flags;
      logic [15:0] ea;
      logic ea_ok;
      logic halt_ok;
      logic hp_irq_ok;
      logic irq_ok;
   } crf_state_t;
endpackage : crf_pkg

// ### shared/crf_alu_if.sv
// Purpose: carrier between register file and its flag adder
// Assumes: one clock domain
// Notes: purely combinational signals
`timescale 1ns/1ps
`default_nettype none
interface crf_alu_if;
   import crf_pkg::*;
   crf_op_t op;
   logic [15:0] a;
   logic [15:0] b;
   logic cin;
   logic half_in;
   logic [15:0] res;
   logic [7:0] flags;
   logic [7:0] flag_mask;
   modport regs (output op, a, b, cin, half_in, input res, flags, flag_mask);
   modport alu (input op, a, b, cin, half_in, output res, flags, flag_mask);
endinterface : crf_alu_if
`default_nettype wire

// ### design/crf_alu.sv
// Purpose: arithmetic with flag generation for the register set
// Assumes: operands stable within the cycle
// Notes: flag_mask marks which flags the operation updates
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.svh"
module crf_alu
   import crf_pkg::*;
(
   crf_alu_if.alu bus
);
   // -------------------------------------------------------------
   // flag arithmetic
   // -------------------------------------------------------------
   logic [`CRF_EXT_W-1:0] sum;
   logic [4:0] nib;
   logic [7:0] adj;
   logic msb_a;
   logic msb_b;
   logic msb_r;
   logic wide;
   logic sub;
   // one adder serves every op; subtraction by inverted operand
   always_comb
   begin
      wide = (bus.op == CRF_OP_ADD16) || (bus.op == CRF_OP_SUB16);
      sub = (bus.op == CRF_OP_SUB8) || (bus.op == CRF_OP_SUB16);
      sum = '0;
      nib = '0;
      adj = 8'h00;
      bus.res = 16'h0000;
      bus.flags = 8'h00;
      bus.flag_mask = 8'h00;
      msb_a = 1'b0;
      msb_b = 1'b0;
      msb_r = 1'b0;
      case (bus.op)
         CRF_OP_ADD8, CRF_OP_ADC8, CRF_OP_SUB8:
         begin
            sum = {12'h000, bus.a[7:0]} + (sub ? {12'h000, ~bus.b[7:0]} : {12'h000, bus.b[7:0]})
                  + {19'h00000, (bus.op == CRF_OP_ADC8) ? bus.cin : sub};
            nib = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]}
                  + {4'h0, (bus.op == CRF_OP_ADC8) & bus.cin};
            bus.res = {8'h00, sum[7:0]};
            msb_a = bus.a[7];
            msb_b = sub ? ~bus.b[7] : bus.b[7];
            msb_r = sum[7];
            bus.flags[`CRF_FLG_CARRY] = sub ? ~sum[8] : sum[8];
            bus.flags[`CRF_FLG_HALF] = nib[4];
            bus.flag_mask = sub ? 8'h0f : 8'h2f;
         end
         CRF_OP_DAA:
         begin
            // correction uses half carry and carry together
            adj[3:0] = (bus.half_in || bus.a[3:0] > 4'h9) ? 4'h6 : 4'h0;
            adj[7:4] = (bus.cin || bus.a[7:4] > 4'h9 ||
                        (bus.a[7:4] > 4'h8 && bus.a[3:0] > 4'h9)) ? 4'h6 : 4'h0;
            sum = {12'h000, bus.a[7:0]} + {12'h000, adj};
            bus.res = {8'h00, sum[7:0]};
            msb_r = sum[7];
            bus.flags[`CRF_FLG_CARRY] = bus.cin | sum[8];
            bus.flag_mask = 8'h0d;
         end
         CRF_OP_ADD16, CRF_OP_SUB16:
         begin
            sum = {4'h0, bus.a} + (sub ? {4'h0, ~bus.b} : {4'h0, bus.b})
                  + {19'h00000, sub};
            bus.res = sum[15:0];
            msb_a = bus.a[15];
            msb_b = sub ? ~bus.b[15] : bus.b[15];
            msb_r = sum[15];
            bus.flags[`CRF_FLG_CARRY] = sub ? ~sum[16] : sum[16];
            bus.flag_mask = 8'h0f;
         end
         default:
         begin
            bus.res = 16'h0000;
         end
      endcase
      bus.flags[`CRF_FLG_NEG] = msb_r;
      bus.flags[`CRF_FLG_ZERO] = wide ? (bus.res == 16'h0000) : (bus.res[7:0] == 8'h00);
      bus.flags[`CRF_FLG_OVF] = (bus.op == CRF_OP_DAA) ? 1'b0
                                : (msb_a == msb_b) && (msb_r != msb_a);
   end
endmodule : crf_alu
`default_nettype wire

// ### tb/crf_dp_model.sv
// Purpose: far-side datapath stand-in raising halt and interrupt requests
// Assumes: requests are levels, changed at the falling edge
// Notes: random so every gate meets both flag states
`timescale 1ns/1ps
`default_nettype none
module crf_dp_model
(
   input wire logic i_sys_clk,
   output logic o_halt_req,
   output logic o_hp_irq_req,
   output logic o_irq_req
);
   // requests quiet until the first falling edge
   initial
   begin
      {o_halt_req, o_hp_irq_req, o_irq_req} = 3'h0;
   end
   // fresh levels each cycle, away from the sampling edge
   always @(negedge i_sys_clk)
   begin
      {o_halt_req, o_hp_irq_req, o_irq_req} <= 3'($urandom);
   end
endmodule : crf_dp_model
`default_nettype wire

// ### tb/cpu_register_file_ccr_bench.sv
// Purpose: self-checking bench for the register set and flags
// Assumes: one result per clock, no handshake
// Notes: reference model kept in ints; registers X until first written
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_ccr_bench
   import crf_pkg::*;
;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_sp_push = 1'b0, i_sp_pop = 1'b0, i_ea_autoidx = 1'b0;
   crf_sel_t i_wr_sel = CRF_SEL_NONE;
   crf_op_t i_op = CRF_OP_NONE;
   crf_base_t i_ea_base = CRF_BASE_IDX1;
   crf_ofs_t i_ea_ofs = CRF_OFS_CONST;
   logic [15:0] i_wr_data = 16'h0, i_op_b = 16'h0, i_ea_const = 16'h0;
   logic [3:0] i_sp_step = 4'h0;
   wire logic hreq, hpreq, ireq;
   logic [7:0] o_acc_hi, o_acc_lo, o_flags;
   logic [15:0] o_dbl_acc, o_idx1, o_idx2, o_stack, o_pc, o_ea;
   logic o_ea_ok, o_halt_ok, o_hp_irq_ok, o_irq_ok;
   int m_hi, m_lo, m_x, m_y, m_s, m_pc, m_f, m_ea, m_eok;
   logic [2:0] m_g;
   int err_total = 0, cmp_count = 0;
   bit live = 0;
   // 20 MHz core clock
   always #25 i_sys_clk = ~i_sys_clk;
   crf_dp_model u_dp (.i_sys_clk(i_sys_clk), .o_halt_req(hreq), .o_hp_irq_req(hpreq),
      .o_irq_req(ireq));
   crf_regs dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wr_sel(i_wr_sel),
      .i_wr_data(i_wr_data), .i_op(i_op), .i_op_b(i_op_b), .i_sp_push(i_sp_push),
      .i_sp_pop(i_sp_pop), .i_sp_step(i_sp_step), .i_ea_base(i_ea_base), .i_ea_ofs(i_ea_ofs),
      .i_ea_const(i_ea_const), .i_ea_autoidx(i_ea_autoidx), .i_halt_req(hreq),
      .i_hp_irq_req(hpreq), .i_irq_req(ireq), .o_acc_hi(o_acc_hi), .o_acc_lo(o_acc_lo),
      .o_dbl_acc(o_dbl_acc), .o_idx1(o_idx1), .o_idx2(o_idx2), .o_stack(o_stack),
      .o_pc(o_pc), .o_flags(o_flags), .o_ea(o_ea), .o_ea_ok(o_ea_ok),
      .o_halt_ok(o_halt_ok), .o_hp_irq_ok(o_hp_irq_ok), .o_irq_ok(o_irq_ok));
   // ---------------------------------------------
   // checking and closing
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic compare_all();
      chk("acc_hi", {8'h0, o_acc_hi}, 16'(m_hi));
      chk("acc_lo", {8'h0, o_acc_lo}, 16'(m_lo));
      chk("dbl_acc", o_dbl_acc, 16'(m_hi * 256 + m_lo));
      chk("idx1", o_idx1, 16'(m_x));
      chk("idx2", o_idx2, 16'(m_y));
      chk("stack", o_stack, 16'(m_s));
      chk("pc", o_pc, 16'(m_pc));
      chk("flags", {8'h0, o_flags}, 16'(m_f));
      chk("ea_ok", {15'h0, o_ea_ok}, 16'(m_eok));
      if (m_eok == 1)
         chk("ea", o_ea, 16'(m_ea));
      chk("gates", {13'h0, o_halt_ok, o_hp_irq_ok, o_irq_ok}, {13'h0, m_g});
   endtask : compare_all
   // ---------------------------------------------
   // reference model, one rising edge
   // ---------------------------------------------
   task automatic model_edge();
      int a, b, r, w, msk, sb, fl, ci, cf, base, ofs;
      // address and gates see the state from before this edge
      base = (i_ea_base == CRF_BASE_IDX1) ? m_x : (i_ea_base == CRF_BASE_IDX2) ? m_y :
         (i_ea_base == CRF_BASE_STACK) ? m_s : m_pc;
      ofs = (i_ea_ofs == CRF_OFS_CONST) ? int'(i_ea_const) : (i_ea_ofs == CRF_OFS_ACC_HI) ?
         m_hi : (i_ea_ofs == CRF_OFS_ACC_LO) ? m_lo : m_hi * 256 + m_lo;
      m_ea = (base + ofs) & 65535;
      m_eok = (i_ea_base == CRF_BASE_PC && i_ea_autoidx) ? 0 : 1;
      m_g = {hreq & ~m_f[7], hpreq & ~m_f[6], ireq & ~m_f[4]};
      w = (i_op == CRF_OP_ADD16 || i_op == CRF_OP_SUB16) ? 16 : 8;
      a = (w == 16) ? m_hi * 256 + m_lo : m_hi;
      msk = (1 << w) - 1;
      sb = 1 << (w - 1);
      b = int'(i_op_b) & msk;
      ci = (i_op == CRF_OP_ADC8) ? (m_f & 1) : 0;
      fl = 0;
      r = 0;
      case (i_op)
         CRF_OP_ADD8, CRF_OP_ADC8, CRF_OP_ADD16:
         begin
            r = a + b + ci;
            fl = (r > msk ? 1 : 0) | ((((a ^ r) & (b ^ r) & sb) != 0) ? 2 : 0);
            if (w == 8 && (a & 15) + (b & 15) + ci > 15)
               fl = fl | 32;
         end
         CRF_OP_SUB8, CRF_OP_SUB16:
         begin
            r = a - b;
            fl = (b > a ? 1 : 0) | ((((a ^ b) & (a ^ r) & sb) != 0) ? 2 : 0);
         end
         CRF_OP_DAA:
         begin
            cf = (m_f[5] || (a & 15) > 9) ? 6 : 0;
            if (m_f[0] || a > 153)
               cf = cf | 96;
            r = a + cf;
            fl = (m_f & 1) | (cf >= 96 ? 1 : 0);
         end
         default: r = 0;
      endcase
      if (i_op != CRF_OP_NONE)
      begin
         r = r & msk;
         fl = fl | ((r & sb) != 0 ? 8 : 0) | (r == 0 ? 4 : 0);
         m_f = (m_f & ~((i_op == CRF_OP_ADD8 || i_op == CRF_OP_ADC8) ? 47 :
            (i_op == CRF_OP_DAA) ? 13 : 15)) | fl; // decimal adjust keeps overflow
         if (w == 16)
            m_lo = r & 255;
         m_hi = (w == 16) ? r >> 8 : r;
      end
      if (i_sp_push)
         m_s = (m_s - int'(i_sp_step)) & 65535;
      else if (i_sp_pop)
         m_s = (m_s + int'(i_sp_step)) & 65535;
      // a direct write beats the operation result
      case (i_wr_sel)
         CRF_SEL_ACC_HI: m_hi = i_wr_data & 255;
         CRF_SEL_ACC_LO: m_lo = i_wr_data & 255;
         CRF_SEL_DBL: {m_hi, m_lo} = {int'(i_wr_data >> 8), int'(i_wr_data & 255)};
         CRF_SEL_IDX1: m_x = i_wr_data;
         CRF_SEL_IDX2: m_y = i_wr_data;
         CRF_SEL_STACK: m_s = i_wr_data;
         CRF_SEL_PC: m_pc = i_wr_data;
         CRF_SEL_FLAGS: m_f = i_wr_data & 255;
         default: m_f = m_f;
      endcase
   endtask : model_edge
   // one request cycle; address fields random, offset held at acc_hi until live
   task automatic step(input crf_sel_t s, input logic [15:0] d, input crf_op_t o,
      input logic [15:0] b, input logic [1:0] pp);
      i_wr_sel = s;
      i_wr_data = d;
      i_op = o;
      i_op_b = b;
      {i_sp_push, i_sp_pop} = pp;
      i_sp_step = 4'($urandom);
      i_ea_base = crf_base_t'($urandom_range(3));
      i_ea_ofs = crf_ofs_t'($urandom_range(3));
      // bases still unknown: keep clear of the address checks
      if (!live)
         i_ea_ofs = CRF_OFS_ACC_HI;
      i_ea_const = 16'($urandom);
      i_ea_autoidx = (i_ea_base == CRF_BASE_PC) ? 1'($urandom) : 1'b0;
      @(posedge i_sys_clk);
      model_edge();
      @(negedge i_sys_clk);
      if (live)
         compare_all();
   endtask : step
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial
   begin
      void'($urandom(45335));
      m_f = 80;
      repeat (2) @(negedge i_sys_clk);
      chk("rst_masks", {14'h0, o_flags[6], o_flags[4]}, 16'h3);
      i_rst_n = 1'b1;
      // every register written before full comparison
      for (int k = 1; k <= 8; k++)
         step(crf_sel_t'(k), 16'($urandom), CRF_OP_NONE, 16'h0, 2'h0);
      step(CRF_SEL_FLAGS, 16'h0, CRF_OP_NONE, 16'h0, 2'h0);
      live = 1;
      step(CRF_SEL_DBL, 16'h1234, CRF_OP_NONE, 16'h0, 2'h0);
      step(CRF_SEL_NONE, 16'h0, CRF_OP_ADD8, 16'h000e, 2'h0);
      // every arithmetic op back to back, some with a clashing write
      for (int o = 1; o <= 6; o++)
         for (int k = 0; k < 8; k++)
            step(k == 3 ? CRF_SEL_ACC_LO : CRF_SEL_NONE, 16'($urandom),
               crf_op_t'(o), 16'($urandom), 2'h0);
      // packed decimal sums then adjust
      for (int k = 0; k < 10; k++)
      begin
         step(CRF_SEL_ACC_HI, 16'($urandom_range(9) * 16 + $urandom_range(9)), CRF_OP_NONE,
            16'h0, 2'h0);
         step(CRF_SEL_NONE, 16'h0, k % 2 ? CRF_OP_ADC8 : CRF_OP_ADD8,
            16'($urandom_range(9) * 16 + $urandom_range(9)), 2'h0);
         step(CRF_SEL_NONE, 16'h0, CRF_OP_DAA, 16'h0, 2'h0);
      end
      // random writes, flag masks and stack steps
      for (int k = 0; k < 60; k++)
         step(crf_sel_t'($urandom_range(8)), 16'($urandom), CRF_OP_NONE, 16'h0,
            2'($urandom_range(2)));
      // second reset: masks set, data kept
      i_rst_n = 1'b0;
      m_f = m_f | 80;
      m_g = 3'h0;
      m_eok = 0;
      @(negedge i_sys_clk);
      compare_all();
      i_rst_n = 1'b1;
      for (int k = 0; k < 20; k++)
         step(CRF_SEL_NONE, 16'h0, crf_op_t'($urandom_range(6)), 16'($urandom), 2'h0);
      end_sim();
   end
   // hang guard at 2000 cycles, far beyond the 172 or so cycles used
   initial
   begin
      #(50 * 2000);
      err_total++;
      end_sim();
   end
endmodule : cpu_register_file_ccr_bench
`default_nettype wire
